//--- rtl/crpc_pkg.sv
// Package for the command ring pointer control block: register offsets,
// field positions, reset values and head report modes.
// Assumes a single core clock and an instruction parser on the same clock.
//
// Overview of operation
// RULE_01 - Tail field bits 20:3, QWord past valid data.
// RULE_02 - Software appends consecutively from tail, never skipping.
// RULE_03 - Dwords before tail hold valid or padding instructions.
// RULE_04 - First command after tail move is batch start.
// RULE_05 - 11-bit wrap count increments on head wrap.
// RULE_06 - Head dword offset advances until it reaches tail.
// RULE_07 - Software sets head before enabling the ring.
// RULE_08 - Program head and tail before enable; empty allowed.
// RULE_09 - Start address bits 31:12, 4KB aligned, uncached.
// RULE_10 - Ring fetches always use the global translation table.
// RULE_11 - Length field 20:12 in pages, zero means one.
// RULE_12 - Event wait bit 11, write one clears.
// RULE_13 - Semaphore wait bit 10, write one clears.
// RULE_14 - Bits 2:1 choose head report interval.
// RULE_15 - Per-process addressing needs report setting two.
// RULE_16 - Enable bit 0 accepted at any time.
// RULE_17 - Pending head bits 31:3 give resume address.
// RULE_18 - Arbitration check consumes pending valid and jumps.
// RULE_19 - Parse only enabled, not waiting, not empty; wrap.
package crpc_pkg;

  // Register byte addresses in the copy engine register space.
  localparam logic [31:0] CRPC_OFS_TAIL    = 32'h0002_2030;
  localparam logic [31:0] CRPC_OFS_HEAD    = 32'h0002_2034;
  localparam logic [31:0] CRPC_OFS_START   = 32'h0002_2038;
  localparam logic [31:0] CRPC_OFS_CTRL    = 32'h0002_203C;
  localparam logic [31:0] CRPC_OFS_PENDING = 32'h0002_2134;

  // Field positions.
  localparam int CRPC_TAIL_LSB  = 3;
  localparam int CRPC_TAIL_MSB  = 20;
  localparam int CRPC_HEAD_LSB  = 2;
  localparam int CRPC_HEAD_MSB  = 20;
  localparam int CRPC_WRAP_LSB  = 21;
  localparam int CRPC_WRAP_MSB  = 31;
  localparam int CRPC_START_LSB = 12;
  localparam int CRPC_START_MSB = 31;
  localparam int CRPC_LEN_LSB   = 12;
  localparam int CRPC_LEN_MSB   = 20;
  localparam int CRPC_EVW_BIT   = 11;
  localparam int CRPC_SEMW_BIT  = 10;
  localparam int CRPC_RPT_LSB   = 1;
  localparam int CRPC_RPT_MSB   = 2;
  localparam int CRPC_EN_BIT    = 0;
  localparam int CRPC_PEND_LSB  = 3;
  localparam int CRPC_PEND_MSB  = 31;
  localparam int CRPC_PVAL_BIT  = 0;

  // Reset values.
  localparam logic [17:0] CRPC_RST_TAIL  = 18'h0_0000;
  localparam logic [18:0] CRPC_RST_HEAD  = 19'h0_0000;
  localparam logic [10:0] CRPC_RST_WRAP  = 11'h000;
  localparam logic [19:0] CRPC_RST_START = 20'h0_0000;
  localparam logic [8:0]  CRPC_RST_LEN   = 9'h000;
  localparam logic [28:0] CRPC_RST_PEND  = 29'h0000_0000;

  // Dwords per 4KB page minus one, appended below the length field.
  localparam logic [9:0]  CRPC_PAGE_LAST = 10'h3FF;

  // Head bits above a report boundary: 64KB, 4KB and 128KB in dwords.
  localparam logic [18:0] CRPC_MASK_64KB  = 19'h7_C000;
  localparam logic [18:0] CRPC_MASK_4KB   = 19'h7_FC00;
  localparam logic [18:0] CRPC_MASK_128KB = 19'h7_8000;

  // Head report interval selection.
  typedef enum logic [1:0] {
    CRPC_RPT_OFF   = 2'h0,
    CRPC_RPT_64KB  = 2'h1,
    CRPC_RPT_4KB   = 2'h2,
    CRPC_RPT_128KB = 2'h3
  } crpc_report_t;

endpackage

//--- rtl/crpc_flag.sv
// Sticky flag with separate set and clear requests.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/100ps
module crpc_flag (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // Requests
  input  wire logic set_req,
  input  wire logic clr_req,
  // State
  output logic      flag_q
);

  // A set arriving in the same cycle as a clear wins, so no event is lost.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= set_req | (flag_q & ~clr_req);
    end
  end

endmodule // crpc_flag

//--- rtl/crpc_ring_ctrl.sv
// Command ring pointer control: tail, head, wrap count, base, length,
// control flags and pending head for the copy engine command streamer.
// The block tracks pointers only; it neither fetches nor decodes commands.
// Assumes the instruction parser and register access run on clk_sys, so no
// input needs synchronising, and that the parser waits for fetch_addr to
// follow each head step before it reports the next one.
`timescale 1ns/100ps
module crpc_ring_ctrl
  import crpc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // Register access port
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire logic [31:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  output logic             reg_rvalid,
  // Parser events
  input  wire logic        parse_advance,
  input  wire logic        event_wait_start,
  input  wire logic        event_cond_clear,
  input  wire logic        sem_wait_start,
  input  wire logic        sem_cond_met,
  input  wire logic        arb_check,
  // Fetch side toward memory
  output logic             fetch_active,
  output logic      [31:0] fetch_addr,
  output logic             fetch_global_tt,
  output logic             ring_empty,
  // Preemption and head reporting
  output logic             preempt_taken,
  output logic             report_req,
  output logic      [31:0] report_data
);

  // Register state. Next-value signals carry the _d ending and feed the
  // flops further down.
  logic [17:0] tail_q;
  logic [18:0] head_q;
  logic [18:0] head_d;
  logic [10:0] wrap_q;
  logic [10:0] wrap_d;
  logic [19:0] start_q;
  logic [8:0]  len_q;
  logic [1:0]  rpt_q;
  logic        en_q;
  logic [28:0] pend_q;
  logic        evw_q;
  logic        semw_q;
  logic        pval_q;

  // Output flops.
  logic [31:0] rdata_q;
  logic        rvalid_q;
  logic        active_q;
  logic [31:0] faddr_q;
  logic        empty_q;
  logic        preempt_q;
  logic        rpt_req_q;
  logic [31:0] rpt_data_q;

  // Address decode. Addresses are compared in full, so aliases never hit
  // a register and unmapped accesses fall through harmlessly.
  wire sel_tail  = (reg_addr == CRPC_OFS_TAIL);
  wire sel_head  = (reg_addr == CRPC_OFS_HEAD);
  wire sel_start = (reg_addr == CRPC_OFS_START);
  wire sel_ctrl  = (reg_addr == CRPC_OFS_CTRL);
  wire sel_pend  = (reg_addr == CRPC_OFS_PENDING);
  wire wr_tail   = reg_wr_en & sel_tail;
  wire wr_head   = reg_wr_en & sel_head;
  wire wr_start  = reg_wr_en & sel_start;
  wire wr_ctrl   = reg_wr_en & sel_ctrl;
  wire wr_pend   = reg_wr_en & sel_pend;

  // Ring status. The head is a dword offset and the tail a QWord offset,
  // so the ring is empty once the head's QWord matches the tail.
  wire        empty_w    = (head_q[18:1] == tail_q); // RULE_06
  wire        waiting_w  = evw_q | semw_q;
  wire        active_w   = en_q & ~waiting_w & ~empty_w; // RULE_19
  wire        step_w     = parse_advance & active_w;
  // Last dword of the ring: a length of zero still gives one page. The wrap
  // is an equality test, so a length cut below the head while the ring runs
  // lets the head pass the end; software must not shrink a live ring.
  wire [18:0] last_dw    = {len_q, CRPC_PAGE_LAST}; // RULE_11
  wire        wrap_w     = step_w & (head_q == last_dw); // RULE_19
  wire [18:0] head_inc   = wrap_w ? CRPC_RST_HEAD : (head_q + 19'h0_0001);
  wire        consume_w  = arb_check & en_q;
  wire        jump_w     = consume_w & pval_q; // RULE_18

  // Preemption target, expressed as a dword offset from the ring base. The
  // subtraction is modular: a pending address outside the ring lands on an
  // arbitrary offset, which is the price of keeping the head a plain offset.
  wire [31:0] base_addr  = {start_q, 12'h000};
  wire [31:0] pend_addr  = {pend_q, 3'h0}; // RULE_17
  wire [31:0] pend_off   = pend_addr - base_addr;

  // Head and wrap count next values. A jump takes the pending address held
  // at the moment of the check; a head write while enabled is undefined.
  always_comb begin
    head_d = head_q;
    wrap_d = wrap_q;
    if (wr_head) begin
      head_d = reg_wdata[CRPC_HEAD_MSB:CRPC_HEAD_LSB];
      wrap_d = reg_wdata[CRPC_WRAP_MSB:CRPC_WRAP_LSB];
    end else if (jump_w) begin
      head_d = pend_off[20:2]; // RULE_18
    end else if (step_w) begin
      head_d = head_inc; // RULE_06
      if (wrap_w) begin
        wrap_d = wrap_q + 11'h001; // RULE_05
      end
    end
  end

  // Head report boundary for the selected interval.
  wire [18:0] rpt_mask = (rpt_q == CRPC_RPT_64KB)  ? CRPC_MASK_64KB :
                         (rpt_q == CRPC_RPT_4KB)   ? CRPC_MASK_4KB :
                         (rpt_q == CRPC_RPT_128KB) ? CRPC_MASK_128KB : 19'h0_0000; // RULE_14
  // A crossing is a change in the head bits above the boundary, which also
  // catches the wrap back to zero when the ring is longer than the interval.
  // Head writes and preemption jumps are not steps and report only when a
  // crossing step falls in the same cycle; software reads the head itself after either.
  wire        cross_w  = step_w & (rpt_q != CRPC_RPT_OFF) &
                         ((head_inc & rpt_mask) != (head_q & rpt_mask)); // RULE_14

  // Read mux; reserved bits read as zero and unmapped addresses read zero.
  wire [31:0] rd_tail  = {11'h000, tail_q, 3'h0};
  wire [31:0] rd_head  = {wrap_q, head_q, 2'h0};
  wire [31:0] rd_start = {start_q, 12'h000};
  wire [31:0] rd_ctrl  = {11'h000, len_q, evw_q, semw_q, 7'h00, rpt_q, en_q};
  wire [31:0] rd_pend  = {pend_q, 2'h0, pval_q};
  wire [31:0] rd_mux   = sel_tail  ? rd_tail  :
                         sel_head  ? rd_head  :
                         sel_start ? rd_start :
                         sel_ctrl  ? rd_ctrl  :
                         sel_pend  ? rd_pend  : 32'h0000_0000;

  // Wait and pending flag requests. Writing one to a wait bit clears it,
  // which drops the ring back into arbitration.
  wire evw_set   = event_wait_start & en_q;
  wire evw_clr   = (wr_ctrl & reg_wdata[CRPC_EVW_BIT]) | event_cond_clear; // RULE_12
  wire semw_set  = sem_wait_start & en_q;
  wire semw_clr  = (wr_ctrl & reg_wdata[CRPC_SEMW_BIT]) | sem_cond_met; // RULE_13
  wire pval_set  = wr_pend & reg_wdata[CRPC_PVAL_BIT]; // RULE_18
  wire pval_clr  = (wr_pend & ~reg_wdata[CRPC_PVAL_BIT]) | consume_w; // RULE_18

  // Next values of the state that fetch_active and ring_empty summarise. The
  // fetch outputs are built from these so that they move at the same edge as
  // the enable, the tail and the wait flags. Built from the present values
  // instead, a disable would leave fetch_active high for one cycle with the
  // table select already low, and a tail move would report a stale empty.
  wire [17:0] tail_d   = wr_tail ? reg_wdata[CRPC_TAIL_MSB:CRPC_TAIL_LSB] : tail_q; // RULE_01
  wire        en_d     = wr_ctrl ? reg_wdata[CRPC_EN_BIT] : en_q; // RULE_16
  // These mirror the flag cells, set winning over clear.
  wire        evw_d    = evw_set | (evw_q & ~evw_clr); // RULE_12
  wire        semw_d   = semw_set | (semw_q & ~semw_clr); // RULE_13
  wire        empty_d  = (head_d[18:1] == tail_d); // RULE_06
  wire        active_d = en_d & ~(evw_d | semw_d) & ~empty_d; // RULE_19

  // Event wait flag; the parser's own set beats a same-cycle clear, so a
  // fresh wait is never lost to a stale clear.
  crpc_flag u_evw_flag (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .set_req (evw_set),
    .clr_req (evw_clr),
    .flag_q  (evw_q)
  );

  // Semaphore wait flag. A met compare clears it just as a software write
  // of one does.
  crpc_flag u_semw_flag (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .set_req (semw_set),
    .clr_req (semw_clr),
    .flag_q  (semw_q)
  );

  // Pending head valid flag; a software set beats a same-cycle consume.
  crpc_flag u_pval_flag (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .set_req (pval_set),
    .clr_req (pval_clr),
    .flag_q  (pval_q)
  );

  // Tail register. Software alone moves it; the device only compares. A head
  // on the second dword of the tail QWord also counts as empty.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tail_q <= CRPC_RST_TAIL;
    end else if (wr_tail) begin
      tail_q <= reg_wdata[CRPC_TAIL_MSB:CRPC_TAIL_LSB]; // RULE_01
    end
  end

  // Head offset and wrap count. The count is a plain 11-bit adder, so it
  // rolls over to zero on its own; together with the head it tags commands.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      head_q <= CRPC_RST_HEAD;
      wrap_q <= CRPC_RST_WRAP;
    end else begin
      head_q <= head_d;
      wrap_q <= wrap_d;
    end
  end

  // Ring base; only bits 31:12 are held, so the base stays page aligned.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      start_q <= CRPC_RST_START;
    end else if (wr_start) begin
      start_q <= reg_wdata[CRPC_START_MSB:CRPC_START_LSB]; // RULE_09
    end
  end

  // Control fields. Enable takes effect at once, whatever is pending. The
  // wait bits live in the flag cells, so a disable leaves a wait standing;
  // software clears it by writing one if the ring is to restart clean.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      len_q <= CRPC_RST_LEN;
      rpt_q <= CRPC_RPT_OFF;
      en_q  <= 1'b0;
    end else if (wr_ctrl) begin
      len_q <= reg_wdata[CRPC_LEN_MSB:CRPC_LEN_LSB]; // RULE_11
      rpt_q <= reg_wdata[CRPC_RPT_MSB:CRPC_RPT_LSB]; // RULE_14
      en_q  <= reg_wdata[CRPC_EN_BIT]; // RULE_16
    end
  end

  // Pending head address. A write here always replaces the address, so the
  // valid bit and the address move together in one access.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pend_q <= CRPC_RST_PEND;
    end else if (wr_pend) begin
      pend_q <= reg_wdata[CRPC_PEND_MSB:CRPC_PEND_LSB]; // RULE_17
    end
  end

  // Read data returns one cycle after the read strobe. The data lines fall
  // to zero between reads so a late sample shows nothing stale.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q  <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= reg_rd_en ? rd_mux : 32'h0000_0000;
      rvalid_q <= reg_rd_en;
    end
  end

  // Fetch outputs. The address follows the next head, so it is current in
  // the cycle after a step; the parser must wait for it before the next step.
  // The ring reads empty out of reset, matching head and tail both at zero.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      active_q <= 1'b0;
      faddr_q  <= 32'h0000_0000;
      empty_q  <= 1'b1;
    end else begin
      active_q <= active_d; // RULE_19
      faddr_q  <= base_addr + {11'h000, head_d, 2'h0}; // RULE_09
      empty_q  <= empty_d; // RULE_06
    end
  end

  // Preemption and head report pulses.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      preempt_q  <= 1'b0;
      rpt_req_q  <= 1'b0;
      rpt_data_q <= 32'h0000_0000;
    end else begin
      preempt_q  <= jump_w; // RULE_18
      rpt_req_q  <= cross_w; // RULE_14
      if (cross_w) begin
        rpt_data_q <= {wrap_d, head_d, 2'h0}; // RULE_05
      end
    end
  end

  // Ring fetches never use a per-process address space; the select is held
  // low only while the ring is off, when nothing is fetched.
  assign fetch_global_tt = en_q; // RULE_10

  // Outputs. Each one is driven straight from a flop, never from logic,
  // so the far side sees clean levels.
  assign reg_rdata     = rdata_q;
  assign reg_rvalid    = rvalid_q;
  assign fetch_active  = active_q;
  assign fetch_addr    = faddr_q;
  assign ring_empty    = empty_q;
  assign preempt_taken = preempt_q;
  assign report_req    = rpt_req_q;
  assign report_data   = rpt_data_q;

endmodule // crpc_ring_ctrl

//--- testbench/crpc_ring_ctrl_sva.sv
// Checker on the ports of the command ring pointer control block.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/100ps
module crpc_ring_ctrl_sva (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Watched ports
  input wire logic reg_rd_en,
  input wire logic reg_rvalid,
  input wire logic parse_advance,
  input wire logic event_wait_start,
  input wire logic sem_wait_start,
  input wire logic arb_check,
  input wire logic fetch_active,
  input wire logic fetch_global_tt,
  input wire logic ring_empty,
  input wire logic preempt_taken,
  input wire logic report_req
);
  // Single domain, so clock and reset are stated once.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // A wait only begins on an enabled ring.
  sequence ev_begin; event_wait_start && fetch_global_tt; endsequence
  sequence sem_begin; sem_wait_start && fetch_global_tt; endsequence
  rd_answer_a: assert property (reg_rd_en |=> reg_rvalid)
    else $error("read not answered");
  global_tt_a: assert property (fetch_active |-> fetch_global_tt)
    else $error("fetch outside global table");
  empty_stop_a: assert property (ring_empty |-> !fetch_active)
    else $error("fetch on empty ring");
  event_wait_a: assert property (ev_begin |-> ##[1:2] !fetch_active)
    else $error("event wait kept fetching");
  sem_wait_a: assert property (sem_begin |-> ##[1:2] !fetch_active)
    else $error("semaphore wait kept fetching");
  preempt_cause_a: assert property (preempt_taken |-> $past(arb_check) && $past(fetch_global_tt))
    else $error("preempt without check");
  report_cause_a: assert property (report_req |-> $past(parse_advance) && $past(fetch_global_tt))
    else $error("report without head step");
  off_idle_a: assert property (!fetch_global_tt [*2] |-> !fetch_active)
    else $error("fetch on disabled ring");
endmodule // crpc_ring_ctrl_sva

bind crpc_ring_ctrl crpc_ring_ctrl_sva u_crpc_ring_ctrl_sva (
  .clk_sys(clk_sys), .rst_b(rst_b), .reg_rd_en(reg_rd_en), .reg_rvalid(reg_rvalid),
  .parse_advance(parse_advance), .event_wait_start(event_wait_start), .sem_wait_start(sem_wait_start),
  .arb_check(arb_check), .fetch_active(fetch_active), .fetch_global_tt(fetch_global_tt),
  .ring_empty(ring_empty), .preempt_taken(preempt_taken), .report_req(report_req)
);

//--- testbench/crpc_mem_model.sv
// Memory side of the command ring: hands one dword a cycle to the parser.
// Assumes fetch_active and fetch_global_tt come from the block.
`timescale 1ns/100ps
module crpc_mem_model (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // Bench stall and fetch side
  input  wire logic run,
  input  wire logic fetch_active,
  input  wire logic fetch_global_tt,
  // Parser event toward the block
  output logic      parse_advance
);
  // Dwords below the tail are all valid and taken in order; run low stalls
  // memory, and late advances after emptying must be refused by the block.
  // Each tail move is taken to open with a batch start, so only the count
  // of dwords handed over matters here.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      parse_advance <= 1'b0;
    end else begin
      parse_advance <= run && fetch_active && fetch_global_tt;
    end
  end
endmodule // crpc_mem_model

//--- testbench/command_ring_pointer_control_test.sv
// Self-checking bench for the command ring pointer control block.
// Assumes the memory model and the bound checker sit beside the design.
`timescale 1ns/100ps
module command_ring_pointer_control_test import crpc_pkg::*;;
  // Stimulus and observed outputs.
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic        reg_wr_en = 1'b0;
  logic        reg_rd_en = 1'b0;
  logic [31:0] reg_addr = 32'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [4:0]  evt = 5'h0;
  logic        run = 1'b0;
  logic [31:0] reg_rdata, fetch_addr, report_data, b;
  logic        reg_rvalid, parse_advance, fetch_active, fetch_global_tt, ring_empty, preempt_taken, report_req;
  logic [31:0] ofs [5] = '{CRPC_OFS_TAIL, CRPC_OFS_HEAD, CRPC_OFS_START, CRPC_OFS_CTRL, CRPC_OFS_PENDING};
  int          fails = 0;
  int          cmp_count = 0;
  int          rpt_n = 0;
  int          rpt_base = 0;
  // Clock and report pulse count.
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (report_req === 1'b1) rpt_n++;
  crpc_ring_ctrl u_crpc_ring_ctrl (.clk_sys(clk_sys), .rst_b(rst_b), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .parse_advance(parse_advance), .event_wait_start(evt[0]),
    .event_cond_clear(evt[1]), .sem_wait_start(evt[2]), .sem_cond_met(evt[3]), .arb_check(evt[4]),
    .fetch_active(fetch_active), .fetch_addr(fetch_addr), .fetch_global_tt(fetch_global_tt),
    .ring_empty(ring_empty), .preempt_taken(preempt_taken), .report_req(report_req),
    .report_data(report_data));
  crpc_mem_model u_crpc_mem_model (.clk_sys(clk_sys), .rst_b(rst_b), .run(run),
    .fetch_active(fetch_active), .fetch_global_tt(fetch_global_tt), .parse_advance(parse_advance));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
  endtask
  // Read data stands one cycle only, so it is taken right after the answer edge.
  task rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    #1;
    chk(32'(reg_rvalid), 32'h1);
    chk(reg_rdata, exp);
  endtask
  task pulse(input logic [4:0] v);
    @(posedge clk_sys);
    evt <= v;
    @(posedge clk_sys);
    evt <= 5'h0;
    #1;
  endtask
  // Lets memory feed the ring until it runs empty, bounded at 40 cycles.
  task drain();
    int n;
    n = 0;
    @(posedge clk_sys);
    run <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    while (ring_empty !== 1'b1 && n < 40) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n == 40) fails++;
    @(posedge clk_sys);
    run <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  task finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // The tests need some 200 cycles; 40000 leaves ample margin.
  initial begin
    #2000000;
    fails++;
    finish_test();
  end
  // Main sequence.
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int i = 0; i < 5; i++) rd(ofs[i], 32'h0);
    wr(32'h0002_2100, 32'hFFFF_FFFF);
    rd(32'h0002_2100, 32'h0);
    $display("test reset_values done");
    wr(CRPC_OFS_TAIL, 32'hFFFF_FFFF);
    rd(CRPC_OFS_TAIL, 32'h001F_FFF8);
    wr(CRPC_OFS_START, 32'hFFFF_FFFF);
    rd(CRPC_OFS_START, 32'hFFFF_F000);
    wr(CRPC_OFS_PENDING, 32'hFFFF_FFFF);
    rd(CRPC_OFS_PENDING, 32'hFFFF_FFF9);
    for (int i = 0; i < 4; i++) begin
      wr(CRPC_OFS_CTRL, 32'h001F_F000 | 32'(i << 1));
      rd(CRPC_OFS_CTRL, 32'h001F_F000 | 32'(i << 1));
    end
    $display("test fields done");
    // Two pages; head starts two dwords before the page boundary.
    wr(CRPC_OFS_START, 32'h0001_0000);
    wr(CRPC_OFS_CTRL, 32'h0000_1000);
    wr(CRPC_OFS_HEAD, 32'h0000_0FF8);
    wr(CRPC_OFS_TAIL, 32'h0000_1008);
    wr(CRPC_OFS_CTRL, 32'h0000_1005);
    drain();
    rd(CRPC_OFS_HEAD, 32'h0000_1008);
    chk(32'(rpt_n), 32'h1);
    chk(report_data, 32'h0000_1000);
    chk(fetch_addr, 32'h0001_1008);
    chk(32'(ring_empty), 32'h1);
    // Coarse intervals: 128KB skips the 64KB crossing that 64KB takes.
    for (int m = 0; m < 3; m++) begin
      rpt_base = rpt_n;
      wr(CRPC_OFS_CTRL, 32'h001F_F000);
      wr(CRPC_OFS_HEAD, (m == 2) ? 32'h0001_FFF8 : 32'h0000_FFF8);
      wr(CRPC_OFS_TAIL, (m == 2) ? 32'h0002_0008 : 32'h0001_0008);
      wr(CRPC_OFS_CTRL, (m == 1) ? 32'h001F_F003 : 32'h001F_F007);
      drain();
      chk(32'(rpt_n - rpt_base), (m == 0) ? 32'h0 : 32'h1);
      chk(report_data, (m == 0) ? 32'h0000_1000 : ((m == 1) ? 32'h0001_0000 : 32'h0002_0000));
    end
    wr(CRPC_OFS_CTRL, 32'h0000_1000);
    wr(CRPC_OFS_HEAD, 32'h0000_1FF8);
    wr(CRPC_OFS_TAIL, 32'h0);
    wr(CRPC_OFS_CTRL, 32'h0000_1001);
    drain();
    rd(CRPC_OFS_HEAD, 32'h0020_0000);
    chk(fetch_addr, 32'h0001_0000);
    chk(32'(rpt_n), 32'h3);
    $display("test head_walk done");
    wr(CRPC_OFS_PENDING, 32'h0001_0101);
    pulse(5'h10);
    chk(32'(preempt_taken), 32'h1);
    rd(CRPC_OFS_PENDING, 32'h0001_0100);
    rd(CRPC_OFS_HEAD, 32'h0020_0100);
    chk(32'(ring_empty), 32'h0);
    pulse(5'h10);
    chk(32'(preempt_taken), 32'h0);
    rd(CRPC_OFS_HEAD, 32'h0020_0100);
    $display("test preempt done");
    for (int k = 0; k < 2; k++) begin
      b = k ? 32'h0000_0400 : 32'h0000_0800;
      pulse(k ? 5'h04 : 5'h01);
      rd(CRPC_OFS_CTRL, 32'h0000_1001 | b);
      chk(32'(fetch_active), 32'h0);
      wr(CRPC_OFS_CTRL, 32'h0000_1001);
      rd(CRPC_OFS_CTRL, 32'h0000_1001 | b);
      wr(CRPC_OFS_CTRL, 32'h0000_1001 | b);
      rd(CRPC_OFS_CTRL, 32'h0000_1001);
      chk(32'(fetch_active), 32'h1);
      pulse(k ? 5'h04 : 5'h01);
      pulse(k ? 5'h08 : 5'h02);
      rd(CRPC_OFS_CTRL, 32'h0000_1001);
    end
    $display("test waits done");
    wr(CRPC_OFS_CTRL, 32'h0000_1000);
    rd(CRPC_OFS_CTRL, 32'h0000_1000);
    chk(32'(fetch_active), 32'h0);
    chk(32'(fetch_global_tt), 32'h0);
    wr(CRPC_OFS_CTRL, 32'h0000_1001);
    rd(CRPC_OFS_CTRL, 32'h0000_1001);
    chk(32'(fetch_active), 32'h1);
    $display("test enable done");
    finish_test();
  end
endmodule // command_ring_pointer_control_test
